/* File: include/lvd_pkg.sv */
// package for the low-voltage detect control block
`default_nettype none
package lvd_pkg;
    localparam logic [15:0] CTRL_OFS      = 16'hff50;
    localparam logic [15:0] LEVEL_OFS     = 16'hff51;
    localparam logic [15:0] IRQ_OFS       = 16'hff52;
    localparam logic [15:0] CAUSE_OFS     = 16'hff53;
    localparam int          ENABLE_BIT    = 7;
    localparam int          MODE_BIT      = 1;
    localparam int          FLAG_BIT      = 0;
    localparam int          MASK_BIT      = 0;
    localparam int          REQ_BIT       = 1;
    localparam int          CAUSE_BIT     = 0;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic [3:0]  LEVEL_RST     = 4'h0;
    localparam logic [3:0]  LEVEL_MAX     = 4'h9;
    localparam logic        MASK_RST      = 1'h1;
    localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage
`default_nettype wire

/* File: rtl/lvd_control.sv */
// low-voltage detect control: registers, synchroniser, reset and interrupt requests
`default_nettype none
// Operation
// RL1 - reset mode: reset while supply below level
// RL2 - interrupt mode: request when supply below level
// RL3 - software: mask, level, enable, wait, poll, mode
// RL4 - software masks interrupt before enabling detection
// RL5 - setting mode with good supply: no reset
// RL6 - stop reset mode: write 00h or ordered clears
// RL7 - every reset sets interrupt mask to one
// RL8 - flag may read set right after enable
// RL9 - software start sequence for interrupt mode
// RL10 - stop interrupt mode: 00h or clear enable
// RL11 - enabling may raise spurious request and flags
// RL12 - handler checks flag, clears request bit one
// RL13 - software waits out fluctuation after reset
// RL14 - detector reset recorded in cause bit zero
// RL15 - software waits fluctuation then clears request
// RL16 - control: enable 7, mode 1, flag 0
// RL17 - level code selects ten levels, resets zero
// RL18 - detector reset keeps control and level
// RL19 - flag drives request only enabled interrupt mode
// RL20 - comparator passes two-stage synchroniser first
// RL21 - disabled: flag zero, no requests
module lvd_control (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        lvResetn,
    input  wire logic        supplyBelow,
    input  wire logic [1:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output var  logic [31:0] readdata,
    output var  logic        waitrequest,
    output var  logic        resetReq,
    output var  logic        lvIrq,
    output var  logic        enableOut,
    output var  logic [3:0]  levelCode
);
    logic        sync1_r, sync2_r, sync1_nxt, sync2_nxt;
    logic        enable_r, mode_r, enable_nxt, mode_nxt;
    logic [3:0]  level_r, level_nxt;
    logic        mask_r, mask_nxt, req_r, req_nxt, cause_r, cause_nxt;
    logic        rst_r, rst_nxt, irq_r, irq_nxt, ack_r, ack_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic        flag, wr0, acc, levelOk;
    logic [15:0] ofs;

    // register index n sits at the control offset plus n; index 0 maps to the control offset
    // a request is taken while waitrequest is high; a write lands only on
    // the edge at which the master sees waitrequest low
    always_comb
    begin
        ofs = lvd_pkg::CTRL_OFS + {14'h0000, address};
        acc = (read | write) & ~ack_r;
        wr0 = write & ack_r & byteenable[0];
        levelOk = writedata[3:0] <= lvd_pkg::LEVEL_MAX;             // RL17
    end

    // two-stage synchroniser on the comparator level
    always_comb
    begin
        sync1_nxt = supplyBelow;                                    // RL20
        sync2_nxt = sync1_r;                                        // RL20
        flag = enable_r & sync2_r;                                  // RL21 RL8 RL11
    end

    // synchroniser restarts on any reset
    always_ff @(posedge clk or negedge resetn or negedge lvResetn)
    begin
        if (!resetn || !lvResetn)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end
        else
        begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    // settings: enable, mode, level and cause
    always_comb
    begin
        enable_nxt = enable_r;
        mode_nxt = mode_r;
        level_nxt = level_r;
        cause_nxt = cause_r;
        if (wr0 && ofs == lvd_pkg::CTRL_OFS)
        begin
            enable_nxt = writedata[lvd_pkg::ENABLE_BIT];            // RL16
            mode_nxt = writedata[lvd_pkg::MODE_BIT];
        end
        if (wr0 && ofs == lvd_pkg::LEVEL_OFS && !enable_r && levelOk)
        begin
            level_nxt = writedata[3:0];                             // RL17
        end
        if (wr0 && ofs == lvd_pkg::CAUSE_OFS && !writedata[lvd_pkg::CAUSE_BIT])
        begin
            cause_nxt = 1'b0;
        end
        // a detector reset in the same cycle as a clear wins
        if (rst_r)
        begin
            cause_nxt = 1'b1;                                       // RL14
        end
    end

    // requests: mask, request flag, reset and interrupt outputs
    always_comb
    begin
        mask_nxt = mask_r;
        req_nxt = req_r;
        if (wr0 && ofs == lvd_pkg::IRQ_OFS)
        begin
            mask_nxt = writedata[lvd_pkg::MASK_BIT];
            req_nxt = writedata[lvd_pkg::REQ_BIT];                  // RL12
        end
        // a new event beats a software clear in the same cycle
        if (flag && enable_r && !mode_r)
        begin
            req_nxt = 1'b1;                                         // RL2 RL19
        end
        rst_nxt = enable_r & mode_r & flag;                         // RL1 RL5 RL21
        irq_nxt = flag & enable_r & ~mode_r & ~mask_r;              // RL19
    end

    // bus answer: waitrequest drops one cycle after the request appears
    always_comb
    begin
        ack_nxt = acc;
        rd_nxt = lvd_pkg::UNMAPPED_DATA;
        if (read && acc)
        begin
            case (ofs)
                lvd_pkg::CTRL_OFS:  rd_nxt = {24'h000000, enable_r, 5'h00, mode_r, flag};
                lvd_pkg::LEVEL_OFS: rd_nxt = {28'h0000000, level_r};
                lvd_pkg::IRQ_OFS:   rd_nxt = {30'h00000000, req_r, mask_r};
                lvd_pkg::CAUSE_OFS: rd_nxt = {31'h00000000, cause_r};
                default:            rd_nxt = lvd_pkg::UNMAPPED_DATA;
            endcase
        end
        else if (ack_r)
        begin
            rd_nxt = rd_r;
        end
    end

    // settings survive the detector reset and clear on other resets
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            enable_r <= lvd_pkg::CTRL_RST[lvd_pkg::ENABLE_BIT];     // RL18
            mode_r <= lvd_pkg::CTRL_RST[lvd_pkg::MODE_BIT];
            level_r <= lvd_pkg::LEVEL_RST;
            cause_r <= 1'b0;
        end
        else
        begin
            enable_r <= enable_nxt;
            mode_r <= mode_nxt;
            level_r <= level_nxt;
            cause_r <= cause_nxt;
        end
    end

    // request state resets on any reset, detector reset included: mask to one, the rest to zero
    always_ff @(posedge clk or negedge resetn or negedge lvResetn)
    begin
        if (!resetn || !lvResetn)
        begin
            mask_r <= lvd_pkg::MASK_RST;                            // RL7
            req_r <= 1'b0;
            rst_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            mask_r <= mask_nxt;
            req_r <= req_nxt;
            rst_r <= rst_nxt;
            irq_r <= irq_nxt;
        end
    end

    // bus state clears on any reset
    always_ff @(posedge clk or negedge resetn or negedge lvResetn)
    begin
        if (!resetn || !lvResetn)
        begin
            ack_r <= 1'b0;
            rd_r <= lvd_pkg::UNMAPPED_DATA;
        end
        else
        begin
            ack_r <= ack_nxt;
            rd_r <= rd_nxt;
        end
    end

    always_comb
    begin
        readdata = rd_r;
        waitrequest = ~ack_r;
        resetReq = rst_r;
        lvIrq = irq_r;
        enableOut = enable_r;
        levelCode = level_r;
    end
endmodule
`default_nettype wire

/* File: bench/lvd_props.sv */
// checker on the lvd_control ports
`default_nettype none
module lvd_props (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       lvResetn,
    input wire logic       supplyBelow,
    input wire logic       read,
    input wire logic       write,
    input wire logic       waitrequest,
    input wire logic       resetReq,
    input wire logic       lvIrq,
    input wire logic       enableOut,
    input wire logic [3:0] levelCode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_rst; resetReq |-> $past(supplyBelow, 3); endproperty
    a_rst: assert property (p_rst) else $error("reset without low supply");
    property p_irq; lvIrq |-> $past(supplyBelow, 3); endproperty
    a_irq: assert property (p_irq) else $error("irq without low supply");
    property p_en; (resetReq || lvIrq) |-> enableOut || $past(enableOut); endproperty
    a_en: assert property (p_en) else $error("request while disabled");
    property p_mx; !(resetReq && lvIrq); endproperty
    a_mx: assert property (p_mx) else $error("reset and irq together");
    property p_lvl; levelCode <= 4'h9; endproperty
    a_lvl: assert property (p_lvl) else $error("bad level code");
    property p_ack; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("late answer");
    property p_keep; !lvResetn |=> $stable(enableOut) && $stable(levelCode); endproperty
    a_keep: assert property (p_keep) else $error("settings lost");
    property p_ten; $changed(enableOut) |-> $past(write); endproperty
    a_ten: assert property (p_ten) else $error("enable moved alone");
    c_rst: cover property (resetReq);
    c_irq: cover property (lvIrq);
    c_lvr: cover property ($fell(lvResetn));
endmodule
bind lvd_control lvd_props u_props (.*);
`default_nettype wire

/* File: bench/lvd_supply_model.sv */
// comparator and reset feedback model
`default_nettype none
module lvd_supply_model (
    input  wire logic clk,
    input  wire logic low,
    input  wire logic powered,
    input  wire logic resetReq,
    output var  logic supplyBelow,
    output var  logic lvResetn
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {supplyBelow, lvResetn} = 2'h1;
    // unpowered comparator gives junk
    always @(posedge clk)
    begin
        supplyBelow <= powered ? low : ~supplyBelow;
        lvResetn    <= ~resetReq;
    end
endmodule
`default_nettype wire

/* File: bench/tb_lvd_control.sv */
// bench for lvd_control
`default_nettype none
module tb_lvd_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, resetn = 0, low = 0, read = 0, write = 0;
    logic [1:0]  address = 0;
    logic [31:0] writedata = 0, q;
    int          err_total = 0, compares = 0, k = 0;
    wire logic   lvResetn, supplyBelow, waitrequest, resetReq, lvIrq, enableOut;
    wire logic [31:0] readdata;
    wire logic [3:0]  levelCode;
    lvd_control u_dut (.clk, .resetn, .lvResetn, .supplyBelow, .address, .read, .write,
        .writedata, .byteenable(4'h1), .readdata, .waitrequest, .resetReq, .lvIrq,
        .enableOut, .levelCode);
    lvd_supply_model u_sup (.clk, .low, .powered(enableOut), .resetReq, .supplyBelow,
        .lvResetn);
    initial forever #25 clk = ~clk;
    task automatic close_out(input int hang);
        err_total += hang;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic acc(input logic [1:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0 && ++n < 20);
        if (n >= 20) close_out(1);
        q = readdata;
        read <= 0;
        write <= 0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [31:0] e);
        acc(a, 0, 0);
        chk(q, e);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1;
        rd(0, 0);
        rd(1, 0);
        rd(2, 1);
        acc(1, 1, 3);
        acc(0, 1, 32'h80);
        repeat (6) @(posedge clk);
        rd(0, 32'h80);
        acc(1, 1, 5);
        acc(2, 1, 0);
        low <= 1;
        repeat (6) @(posedge clk);
        chk(lvIrq, 1);
        rd(0, 32'h81);
        rd(2, 2);
        low <= 0;
        acc(0, 1, 0);
        rd(0, 0);
        chk(lvIrq, 0);
        acc(1, 1, 32'ha);
        rd(1, 3);
        acc(2, 1, 1);
        acc(0, 1, 32'h80);
        repeat (6) @(posedge clk);
        acc(0, 1, 32'h82);
        repeat (6) @(posedge clk);
        chk(resetReq, 0);
        low <= 1;
        do @(posedge clk); while (lvResetn !== 1'b0 && ++k < 20);
        chk(lvResetn, 0);
        low <= 0;
        repeat (8) @(posedge clk);
        rd(0, 32'h82);
        rd(3, 1);
        rd(2, 1);
        acc(0, 1, 0);
        rd(0, 0);
        close_out(0);
    end
endmodule
`default_nettype wire
